// *** design/memory_mode_decoder.sv ***
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module memory_mode_decoder
  import mode_decoder_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] addr_hi,
  input wire logic data_read_n,
  input wire logic data_write_n,
  input wire logic code_fetch_strobe_n,
  input wire logic reset_in_n,
  input wire logic switch_run_input,
  input wire logic [3:0] option_in,
  output logic net_ctrl_select,
  output logic xio_window_sel_n,
  output logic reset_out_hi,
  output logic reset_out_lo,
  output logic option_out,
  output logic prog_led_n,
  output logic run_led_n,
  output logic flash_sel_n,
  output logic flash_rd_n,
  output logic flash_wr_n,
  output logic sram_sel_n,
  output logic sram_rd_n,
  output logic sram_wr_n,
  output logic [UPPER_ADDR_W-1:0] upper_mem_addr
);
  typedef struct packed {
    logic program_mode_flag;
    logic rst_in_prev;
    logic led_test;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic prog_led_n;
    logic run_led_n;
  } state_s;

  state_s state_ff;
  state_s nxt_state;
  logic [31:0] read_val;
  logic mapped;

  // Register read mux, evaluated in the setup phase
  // Unmapped offsets read as zero and raise the error flag
  always_comb begin
    read_val = 32'h0;
    mapped = 1'b1;
    if (paddr == STATUS_OFS) begin
      read_val[STAT_MODE_BIT] = state_ff.program_mode_flag;
      read_val[STAT_RST_BIT] = reset_in_n;
      read_val[STAT_OPT_LSB +: 4] = option_in;
    end else if (paddr == CTRL_OFS) begin
      read_val[CTRL_LEDTEST_BIT] = state_ff.led_test;
    end else begin
      mapped = 1'b0;
    end
  end

  // Next state: mode capture and APB handshake
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rst_in_prev = reset_in_n;
    // [R4] load inverse of switch on reset fall only
    if (state_ff.rst_in_prev && !reset_in_n) begin
      nxt_state.program_mode_flag = !switch_run_input;
    end
    // Answer is prepared in setup so ready comes from a flop
    nxt_state.ready = 1'b0;
    nxt_state.err = 1'b0;
    if (psel && !penable) begin
      nxt_state.ready = 1'b1;
      nxt_state.err = !mapped;
      nxt_state.rdata = pwrite ? 32'h0 : read_val;
    end
    if (psel && penable && state_ff.ready && pwrite && paddr == CTRL_OFS) begin
      nxt_state.led_test = pwdata[CTRL_LEDTEST_BIT];
    end
    // [R13] indicators from next mode
    nxt_state.prog_led_n = !nxt_state.program_mode_flag && !nxt_state.led_test;
    nxt_state.run_led_n = nxt_state.program_mode_flag && !nxt_state.led_test;
  end

  // Async reset leaves the board in program mode with the LED test off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '{program_mode_flag: MODE_RST, rst_in_prev: RST_IN_PREV_RST,
                    led_test: CTRL_LEDTEST_RST, rdata: 32'h0, ready: 1'b0, err: 1'b0,
                    prog_led_n: PROG_LED_N_RST, run_led_n: RUN_LED_N_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bus answer straight from its flops
  assign prdata = state_ff.rdata;
  assign pready = state_ff.ready;
  assign pslverr = state_ff.err;
  // [R5] option output tracks mode
  assign option_out = state_ff.program_mode_flag;
  // [R13] indicators from flops
  assign prog_led_n = state_ff.prog_led_n;
  assign run_led_n = state_ff.run_led_n;
  // [R3] reset buffering, left unregistered so reset reaches parts at once
  assign reset_out_hi = !reset_in_n;
  assign reset_out_lo = reset_in_n;
  // [R12] no bank switching
  assign upper_mem_addr = UPPER_ADDR_VAL;

  // Decode kept apart so the bus logic never adds delay to the strobes
  strobe_decoder u_dec (
    .prog_mode(state_ff.program_mode_flag),
    .addr_hi(addr_hi),
    .data_read_n(data_read_n),
    .data_write_n(data_write_n),
    .code_fetch_strobe_n(code_fetch_strobe_n),
    .net_ctrl_select(net_ctrl_select),
    .xio_window_sel_n(xio_window_sel_n),
    .flash_sel_n(flash_sel_n),
    .flash_rd_n(flash_rd_n),
    .flash_wr_n(flash_wr_n),
    .sram_sel_n(sram_sel_n),
    .sram_rd_n(sram_rd_n),
    .sram_wr_n(sram_wr_n)
  );

  // Every check samples on the bus clock; the decode settles within the cycle,
  // so a check at each edge sees the value that stood through that cycle
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // [R1] network window decode
  chk_net_decode: assert property (net_ctrl_select == (addr_hi == 8'hfd)) // [R1]
    else $error("network select wrong for address");

  // [R2] expansion window decode
  chk_xio_decode: assert property (!xio_window_sel_n == (addr_hi == 8'hfe)) // [R2]
    else $error("expansion select wrong for address");

  // [R3] reset buffer copies
  chk_reset_copies: assert property ( // [R3]
      reset_out_hi == !reset_in_n && reset_out_lo == reset_in_n)
    else $error("reset outputs wrong");

  // [R4] capture at reset fall
  chk_mode_capture: assert property ( // [R4]
      $fell(reset_in_n) |=> option_out == !$past(switch_run_input))
    else $error("mode not captured at reset fall");

  // [R4] switch alone ignored
  chk_mode_hold: assert property (!$fell(reset_in_n) |=> $stable(option_out)) // [R4]
    else $error("mode changed without reset edge");

  // [R6] program mode strobes
  chk_prog_strobes: assert property ( // [R6]
      option_out |-> sram_sel_n && sram_rd_n && sram_wr_n
      && flash_sel_n == (data_read_n & data_write_n)
      && flash_rd_n == data_read_n && flash_wr_n == data_write_n)
    else $error("program mode strobes wrong");

  // [R7] run mode RAM strobes
  chk_run_strobes: assert property ( // [R7]
      !option_out |-> sram_sel_n == ((data_read_n & data_write_n) | (addr_hi == 8'hfe))
      && sram_rd_n == data_read_n && sram_wr_n == data_write_n)
    else $error("run mode strobes wrong");

  // [R8] run mode flash strobes
  chk_run_flash: assert property ( // [R8]
      !option_out |-> flash_sel_n == code_fetch_strobe_n
      && flash_rd_n == code_fetch_strobe_n && flash_wr_n)
    else $error("run mode flash strobes wrong");

  // [R12] bank bits held low
  chk_upper_zero: assert property (upper_mem_addr == 3'h0) // [R12]
    else $error("upper address not zero");

  // [R13] indicators follow mode
  chk_led_pair: assert property ( // [R13]
      !state_ff.led_test |-> prog_led_n == !option_out && run_led_n == option_out)
    else $error("mode indicators wrong");

  // LED test lights both indicators whatever the mode
  chk_led_test: assert property (state_ff.led_test |-> !prog_led_n && !run_led_n)
    else $error("LED test does not light both indicators");

  // Register bus answers one cycle after setup and only for that cycle
  chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("register answer timing wrong");

  // No answer appears without a setup phase just before it
  chk_apb_origin: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("register answer without setup");

  // The error flag only rides on an answer, and that answer carries no data
  chk_apb_error: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");

  // A control write lands at the edge that ends its access phase
  chk_ctrl_write: assert property (
      psel && penable && pready && pwrite && paddr == CTRL_OFS
      |=> state_ff.led_test == $past(pwdata[CTRL_LEDTEST_BIT]))
    else $error("control write lost");

  // Without such a write the control bit holds, so reads never disturb it
  chk_ctrl_hold: assert property (
      !(psel && penable && pready && pwrite && paddr == CTRL_OFS)
      |=> $stable(state_ff.led_test))
    else $error("control bit changed without a write");

  // A status read reports the mode, the reset input and the jumpers at setup
  chk_status_read: assert property (
      psel && !penable && !pwrite && paddr == STATUS_OFS
      |=> prdata[STAT_MODE_BIT] == $past(option_out)
      && prdata[STAT_RST_BIT] == $past(reset_in_n)
      && prdata[STAT_OPT_LSB +: 4] == $past(option_in))
    else $error("status read wrong");
endmodule

// *** design/mode_decoder_pkg.sv ***
// Notes on behaviour
// [R1] Network select high for 0xFD00-0xFDFF only
// [R2] Expansion select low for 0xFE00-0xFEFF only
// [R3] Reset out: inverted high copy, plain low copy
// [R4] Mode captured from switch at reset fall
// [R5] Option output high in program, low run
// [R6] Program mode: flash on strobes, RAM idle
// [R7] Run mode: RAM on strobes outside window
// [R8] Run mode: flash follows code fetch strobe
// [R9] Option inputs low when jumpered, else high
// [R10] Board ties option output to external access
// [R11] Partner supplies demultiplexed address and data
// [R12] Upper memory address bits always zero
// [R13] Program and run LEDs complementary, active low; the LED test lights both at once
// [R14] Selects and strobes combinational, no latency
package mode_decoder_pkg;
  // Upper address byte of each decoded window
  localparam logic [7:0] NET_WINDOW = 8'hfd;
  localparam logic [7:0] XIO_WINDOW = 8'hfe;
  localparam int UPPER_ADDR_W = 3;
  localparam logic [UPPER_ADDR_W-1:0] UPPER_ADDR_VAL = 3'h0;
  // APB register map, byte addresses
  localparam logic [11:0] STATUS_OFS = 12'h000;
  localparam logic [11:0] CTRL_OFS = 12'h004;
  // Status field positions
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_RST_BIT = 1;
  localparam int STAT_OPT_LSB = 4;
  // Control field positions and reset values
  localparam int CTRL_LEDTEST_BIT = 0;
  localparam logic CTRL_LEDTEST_RST = 1'b0;
  // Mode after power-up reset: program mode until a reset edge is seen
  localparam logic MODE_RST = 1'b1;
  // Reset input history starts at its idle level so no false fall follows reset
  localparam logic RST_IN_PREV_RST = 1'b1;
  // Indicators after reset agree with program mode and the LED test off
  localparam logic PROG_LED_N_RST = 1'b0;
  localparam logic RUN_LED_N_RST = 1'b1;
endpackage

// *** design/strobe_decoder.sv ***
`timescale 1ns/1ps
module strobe_decoder
  import mode_decoder_pkg::*;
(
  input wire logic prog_mode,
  input wire logic [7:0] addr_hi,
  input wire logic data_read_n,
  input wire logic data_write_n,
  input wire logic code_fetch_strobe_n,
  output logic net_ctrl_select,
  output logic xio_window_sel_n,
  output logic flash_sel_n,
  output logic flash_rd_n,
  output logic flash_wr_n,
  output logic sram_sel_n,
  output logic sram_rd_n,
  output logic sram_wr_n
);
  // Pure decode so the bus sees no pipeline delay
  // [R14] combinational strobes
  always_comb begin
    // [R1] network window decode
    net_ctrl_select = (addr_hi == NET_WINDOW);
    // [R2] expansion window decode
    xio_window_sel_n = !(addr_hi == XIO_WINDOW);
    if (prog_mode) begin
      // [R6] flash as data memory
      flash_sel_n = data_read_n & data_write_n;
      flash_rd_n = data_read_n;
      flash_wr_n = data_write_n;
      sram_sel_n = 1'b1;
      sram_rd_n = 1'b1;
      sram_wr_n = 1'b1;
    end else begin
      // [R8] flash as code memory
      flash_sel_n = code_fetch_strobe_n;
      flash_rd_n = code_fetch_strobe_n;
      flash_wr_n = 1'b1;
      // [R7] RAM as data memory
      sram_sel_n = (data_read_n & data_write_n) | (addr_hi == XIO_WINDOW);
      sram_rd_n = data_read_n;
      sram_wr_n = data_write_n;
    end
  end
endmodule

// *** verif/cpu_bus_model.sv ***
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic pclk,
  input wire logic external_access_n,
  output logic [7:0] addr_hi,
  output logic data_read_n,
  output logic data_write_n,
  output logic code_fetch_strobe_n
);
  // Bus starts idle with every strobe released
  initial begin
    addr_hi = 8'h00;
    {data_read_n, data_write_n, code_fetch_strobe_n} = 3'h7;
  end
  // demultiplexed address and strobes
  // Held a full cycle so the decode has settled when the caller looks
  task automatic cyc(input logic [7:0] a, input logic [2:0] s);
    @(posedge pclk);
    addr_hi <= a;
    {data_read_n, data_write_n} <= s[2:1];
    // external access high: code fetched inside, fetch strobe rests
    code_fetch_strobe_n <= s[0] | external_access_n;
    @(posedge pclk);
  endtask
endmodule

// *** verif/tb_memory_mode_decoder.sv ***
`timescale 1ns/1ps
module tb_memory_mode_decoder;
  import mode_decoder_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, reset_in_n = 1'h1, switch_run_input = 1'h0;
  // jumpers fitted on options zero and two
  logic [3:0] option_in = 4'ha;
  logic [7:0] addr_hi;
  logic data_read_n, data_write_n, code_fetch_strobe_n, net_ctrl_select, xio_window_sel_n;
  logic reset_out_hi, reset_out_lo, option_out, prog_led_n, run_led_n;
  logic flash_sel_n, flash_rd_n, flash_wr_n, sram_sel_n, sram_rd_n, sram_wr_n;
  logic [UPPER_ADDR_W-1:0] upper_mem_addr;
  // board strap ties the option output to external access
  logic external_access_n;
  assign external_access_n = option_out;
  int num_errors = 0, n_tests = 0;
  memory_mode_decoder dut_u (.*);
  cpu_bus_model cpu_u (.*);
  // Bus clock, 8 ns period
  always #4 pclk = ~pclk;
  // Compare with case equality so unknowns never match
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Sweep all strobe mixes inside and outside the expansion window
  task automatic sweep(input logic m);
    logic r, w, p, x;
    logic [5:0] s;
    for (int i = 0; i < 16; i++) begin
      cpu_u.cyc(i[3] ? XIO_WINDOW : 8'h10, i[2:0]);
      {x, r, w, p} = i[3:0];
      s = {flash_sel_n, flash_rd_n, flash_wr_n, sram_sel_n, sram_rd_n, sram_wr_n};
      if (m)
        chk(s, {r & w, r, w, 3'h7}, "prog strobes");
      else
        chk(s, {p, p, 1'h1, (r & w) | x, r, w}, "run strobes");
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(q, 32'ha3, "status"); // reset mode
    chk({option_out, prog_led_n, run_led_n}, 3'h5, "prog mode");
    apb(1'h1, CTRL_OFS, 32'h1);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk({q[0], prog_led_n, run_led_n}, 3'h4, "led test");
    apb(1'h1, CTRL_OFS, 32'h0);
    apb(1'h1, STATUS_OFS, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk({e, q}, 33'h100000000, "unmapped");
    apb(1'h0, STATUS_OFS, 32'h0);
    chk({e, q}, 33'h0000000a3, "status kept");
    for (int i = 0; i < 4; i++) begin
      cpu_u.cyc(8'hfc + i[7:0], 3'h7);
      chk(net_ctrl_select, i == 1, "net select"); // net
      chk(xio_window_sel_n, i != 2, "xio select"); // window
    end
    chk(upper_mem_addr, UPPER_ADDR_VAL, "upper addr"); // bank bits
    sweep(1'h1);
    switch_run_input <= 1'h1;
    reset_in_n <= 1'h0;
    repeat (3) @(posedge pclk);
    chk({reset_out_hi, reset_out_lo}, 2'h2, "reset out"); // copies
    reset_in_n <= 1'h1;
    // Moving the switch back alone must not leave run mode
    switch_run_input <= 1'h0;
    repeat (3) @(posedge pclk);
    chk({option_out, prog_led_n, run_led_n, reset_out_hi}, 4'h4, "run mode");
    sweep(1'h0);
    // A second board reset with the switch at program returns to program mode
    reset_in_n <= 1'h0;
    repeat (2) @(posedge pclk);
    reset_in_n <= 1'h1;
    repeat (2) @(posedge pclk);
    chk({option_out, prog_led_n, run_led_n, reset_out_lo}, 4'hb, "back to prog");
    end_of_test();
  end
  // Watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
endmodule
